// File: hdl/flash_status_pkg.sv
// constants, bit layout and states of the first status register bank
// assumes a 25 MHz system clock and a serial link clocked from outside
package flash_status_pkg;

   // ------------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_ENABLE_WRITES  = 8'h06;
   localparam logic [7:0] OP_DISABLE_WRITES = 8'h04;
   localparam logic [7:0] OP_ENABLE_VOLATILE = 8'h50;
   localparam logic [7:0] OP_REG_WRITE      = 8'h01;
   localparam logic [7:0] OP_ANY_WRITE      = 8'h71;
   localparam logic [7:0] OP_ANY_READ       = 8'h65;
   localparam logic [7:0] OP_STATUS1_READ   = 8'h05;
   localparam logic [7:0] OP_CLEAR_STATUS   = 8'h30;
   localparam logic [7:0] OP_RESET_ARM      = 8'h66;
   localparam logic [7:0] OP_RESET_GO       = 8'h99;
   localparam logic [7:0] OP_STATUS2_READ   = 8'h07;
   localparam logic [7:0] OP_CONFIG1_READ   = 8'h35;
   localparam logic [7:0] OP_CONFIG2_READ   = 8'h15;
   localparam logic [7:0] OP_CONFIG3_READ   = 8'h33;
   localparam logic [7:0] OP_SUSPEND        = 8'h75;
   localparam logic [7:0] OP_PROGRAM        = 8'h02;
   localparam logic [7:0] OP_ERASE          = 8'h20;

   // ------------------------------------------------------------------
   // status register bit positions and defaults
   // ------------------------------------------------------------------
   localparam int LOCK_BIT   = 7;
   localparam int SIZE_BIT   = 6;
   localparam int TB_BIT     = 5;
   localparam int BP_MSB     = 4;
   localparam int BP_LSB     = 2;
   localparam int WEL_BIT    = 1;
   localparam int BUSY_BIT   = 0;
   localparam int EFAIL_BIT  = 6;
   localparam int PFAIL_BIT  = 5;
   localparam logic [7:0] NV_RESET      = 8'h00;
   localparam logic       LATCH_DEFAULT = 1'b0;
   localparam logic       BUSY_DEFAULT  = 1'b0;

   // ------------------------------------------------------------------
   // any-register addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PERSIST = 8'h00;
   localparam logic [7:0] ADDR_LIVE    = 8'h80;
   localparam logic [7:0] ADDR_STATUS2 = 8'h81;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int NV_WRITE_NS     = 2000;
   localparam int NV_WRITE_CYCLES =
      (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] NV_WRITE_LOAD = 7'(NV_WRITE_CYCLES - 1);
   localparam logic [4:0] BITS_SAT = 5'h18;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARRAY   = 2'b01,
      ST_NVWRITE = 2'b11,
      ST_FAILED  = 2'b10
   } op_state_t;

endpackage : flash_status_pkg

// File: hdl/flash_status_protect_regs.sv
// first status register bank of a serial flash, with write protection,
// write-enable latch and busy filtering of serial register commands
// assumes an outside array engine on sys_clk and a host on the spi pins
//
// Functional notes
// [R1] lock bit set and protect pin low: register-modifying commands ignored
// [R2] protect pin high: register writes accepted even with lock bit set
// [R3] lock bit clear: protect pin ignored, register writes allowed
// [R4] protect pin affects only the protected register set
// [R5] changing persistent lock default updates the live lock bit
// [R6] four-wire or four-bit mode forces internal protect level high
// [R7] top-bottom select: 0 protects from top, 1 from address zero
// [R8] changing persistent top-bottom default updates live select bit
// [R9] block-protect bits choose the array part shielded from changes
// [R10] program, write or erase refused unless latch is set
// [R11] enable-writes command sets the latch; host issues it first
// [R12] disable-writes command clears the latch
// [R13] successful program or erase completion clears the latch
// [R14] latch may stay set after failure; host clears via clear-status
// [R15] every reset loads the latch from its default bit
// [R16] register writes leave latch and busy flag untouched; here a persistent write sets busy during its write delay
// [R17] busy flag set: new operation commands ignored
// [R18] while busy only reads, suspend, clear-status and reset pair pass
// [R19] suspend accepted only during array program or erase
// [R20] failure flags set while busy keep busy until clear-status
// [R21] persistent layout: lock 7, size 6, top-bottom 5, protect 4:2
// [R22] latch and busy defaults fixed, no command alters them
// [R23] block-size bit: 0 means 64 KB blocks, 1 means 4 KB sectors
// [R24] live bits take defaults after every reset
// [R25] reset copies persistent defaults into the live bits
`timescale 1ns/1ps
module flash_status_protect_regs
   import flash_status_pkg::*;
(
   // system side
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // serial link pins
   input  wire logic       spiClk,
   input  wire logic       spiSelN,
   input  wire logic       spiDataIn,
   output logic            spiDataOut,
   output logic            spiOutEnN,
   input  wire logic       protectPinN,
   // configuration levels from the config registers
   input  wire logic       fourWireMode,
   input  wire logic       fourBitIoMode,
   // array operation engine
   output logic            opStart,
   output logic            opErase,
   output logic            suspendReq,
   output logic            abortOp,
   input  wire logic       opDone,
   input  wire logic       programFail,
   input  wire logic       eraseFail,
   // register state
   output logic [7:0]      status1Live,
   output logic [7:0]      status1Persist,
   output logic [2:0]      blockProtect,
   output logic            protectFromBottom,
   output logic            sectorGranule
);

   // ------------------------------------------------------------------
   // link side: bit capture and reply shifting
   // ------------------------------------------------------------------
   logic [4:0]  bitCnt;
   logic [6:0]  shiftIn;
   logic [7:0]  txShift;
   logic [7:0]  rdOp;
   logic [7:0]  rdAddr;
   logic        linkTog;
   logic [7:0]  linkByte;
   logic [1:0]  linkIdx;
   logic        pubSync1;
   logic        pubSync2;
   logic        pubSeen;
   logic [23:0] shadow;
   logic [7:0]  newByte;
   logic        byteEnd;
   logic        pubReq;
   logic [23:0] pubData;

   assign newByte = {shiftIn, spiDataIn};
   assign byteEnd = (bitCnt[2:0] == 3'h7) && (bitCnt != BITS_SAT);

   // reply byte for a read command
   function automatic logic [7:0] replyByte(
      input logic [7:0]  op,
      input logic [7:0]  addr,
      input logic [23:0] sh
   );
      logic [7:0] r;
      r = 8'h00;
      case (op)
         OP_STATUS1_READ: r = sh[7:0];
         OP_STATUS2_READ: r = sh[23:16];
         OP_ANY_READ: begin
            if (addr == ADDR_PERSIST) r = sh[15:8];
            else if (addr == ADDR_LIVE) r = sh[7:0];
            else if (addr == ADDR_STATUS2) r = sh[23:16];
            else r = 8'h00;
         end
         default: r = 8'h00;
      endcase
      return r;
   endfunction : replyByte

   // frame bit counter and input shifter, cleared between frames
   always_ff @(posedge spiClk or posedge spiSelN or posedge rst) begin
      if (rst || spiSelN) begin
         bitCnt  <= 5'h00;
         shiftIn <= 7'h00;
      end else begin
         shiftIn <= newByte[6:0];
         if (bitCnt != BITS_SAT) bitCnt <= bitCnt + 5'h01;
      end
   end

   // reply loader; status reads repeat for three reply bytes, then zeros once the bit counter saturates
   always_ff @(posedge spiClk or posedge spiSelN or posedge rst) begin
      if (rst || spiSelN) begin
         txShift <= 8'h00;
         rdOp    <= 8'h00;
         rdAddr  <= 8'h00;
      end else if (bitCnt == 5'h07) begin
         rdOp    <= newByte;
         txShift <= replyByte(newByte, 8'h00, shadow);
      end else if (bitCnt == 5'h0F) begin
         rdAddr  <= newByte;
         txShift <= replyByte(rdOp, newByte, shadow);
      end else if (bitCnt[2:0] == 3'h7) begin
         txShift <= replyByte(rdOp, rdAddr, shadow);
      end else begin
         txShift <= {txShift[6:0], 1'b0};
      end
   end

   // each of the first three bytes of a frame is handed over with a toggle
   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         linkTog  <= 1'b0;
         linkByte <= 8'h00;
         linkIdx  <= 2'h0;
      end else if (byteEnd) begin
         linkTog  <= ~linkTog;
         linkByte <= newByte;
         linkIdx  <= bitCnt[4:3];
      end
   end

   // reply bit driven on the falling edge
   always_ff @(negedge spiClk or posedge spiSelN or posedge rst) begin
      if (rst || spiSelN) begin
         spiDataOut <= 1'b0;
         spiOutEnN  <= 1'b1;
      end else begin
         spiDataOut <= txShift[7];
         spiOutEnN  <= 1'b0;
      end
   end

   // register snapshot taken over from the system side
   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         pubSync1 <= 1'b0;
         pubSync2 <= 1'b0;
         pubSeen  <= 1'b0;
         shadow   <= 24'h000000;
      end else begin
         pubSync1 <= pubReq;
         pubSync2 <= pubSync1;
         if (pubSync2 != pubSeen) begin
            pubSeen <= pubSync2;
            shadow  <= pubData;
         end
      end
   end

   // ------------------------------------------------------------------
   // system side: synchronisers
   // ------------------------------------------------------------------
   logic togS1, togS2, togSeen;
   logic ackS1, ackS2;
   logic wpS1, wpS2;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         togS1   <= 1'b0;
         togS2   <= 1'b0;
         togSeen <= 1'b0;
         ackS1   <= 1'b0;
         ackS2   <= 1'b0;
         wpS1    <= 1'b0;
         wpS2    <= 1'b0;
      end else begin
         togS1   <= linkTog;
         togS2   <= togS1;
         togSeen <= togS2;
         ackS1   <= pubSeen;
         ackS2   <= ackS1;
         wpS1    <= protectPinN;
         wpS2    <= wpS1;
      end
   end

   // ------------------------------------------------------------------
   // system side: command decode
   // ------------------------------------------------------------------
   op_state_t   state;
   logic [6:0]  nvCount;
   logic [7:2]  liveBits;
   logic [7:2]  nvBits;
   logic        write_enable_latch;
   logic        volTarget;
   logic        resetArmed;
   logic        progFail;
   logic        eraseFailFlag;
   logic [7:0]  curOp;
   logic [7:0]  anyAddr;
   logic        busy;
   logic        evValid;
   logic        wpLevel;
   logic        regUnlocked;
   logic        doWren, doWrdi, doWrenV, doClsr, doArm, doReset;
   logic        doSuspend, doProg, doErase, doLiveWr, doNvWr;
   logic [7:0]  wrData;

   // commands that pass while busy
   function automatic logic passWhileBusy(input logic [7:0] op);
      case (op)
         OP_STATUS1_READ, OP_STATUS2_READ, OP_ANY_READ,
         OP_SUSPEND, OP_CLEAR_STATUS, OP_CONFIG1_READ,
         OP_CONFIG2_READ, OP_CONFIG3_READ,
         OP_RESET_ARM, OP_RESET_GO: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : passWhileBusy

   assign busy    = (state != ST_IDLE);
   assign evValid = togS2 ^ togSeen;
   // internal protect level, pin repurposed as data_line_two
   assign wpLevel = wpS2 | fourWireMode | fourBitIoMode;      // [R6]
   assign regUnlocked = ~liveBits[LOCK_BIT] | wpLevel;  // [R1] [R2] [R3]

   always_comb begin
      doWren    = 1'b0;
      doWrdi    = 1'b0;
      doWrenV   = 1'b0;
      doClsr    = 1'b0;
      doArm     = 1'b0;
      doReset   = 1'b0;
      doSuspend = 1'b0;
      doProg    = 1'b0;
      doErase   = 1'b0;
      doLiveWr  = 1'b0;
      doNvWr    = 1'b0;
      wrData    = linkByte;
      if (evValid && linkIdx == 2'h0) begin
         if (!busy || passWhileBusy(linkByte)) begin     // [R17] [R18]
            // write-enable commands ignore the protect pin
            doWren  = (linkByte == OP_ENABLE_WRITES);    // [R4] [R11]
            doWrenV = (linkByte == OP_ENABLE_VOLATILE);
            doWrdi  = (linkByte == OP_DISABLE_WRITES);   // [R12]
            doClsr  = (linkByte == OP_CLEAR_STATUS);
            doArm   = (linkByte == OP_RESET_ARM);
            doReset = (linkByte == OP_RESET_GO) && resetArmed;
            doSuspend = (linkByte == OP_SUSPEND) &&
                        (state == ST_ARRAY);             // [R19]
            doProg  = (linkByte == OP_PROGRAM) && write_enable_latch;   // [R10]
            doErase = (linkByte == OP_ERASE) && write_enable_latch;     // [R10]
         end
      end else if (evValid && !busy && write_enable_latch && regUnlocked) begin
         if (linkIdx == 2'h1 && curOp == OP_REG_WRITE) begin
            doLiveWr = volTarget;                        // [R1] [R10]
            doNvWr   = ~volTarget;
         end else if (linkIdx == 2'h2 && curOp == OP_ANY_WRITE) begin
            doLiveWr = (anyAddr == ADDR_LIVE);
            doNvWr   = (anyAddr == ADDR_PERSIST);
         end
      end
   end

   // frame context for multi-byte commands
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         curOp   <= 8'h00;
         anyAddr <= 8'h00;
      end else if (evValid) begin
         if (linkIdx == 2'h0) curOp <= linkByte;
         if (linkIdx == 2'h1) anyAddr <= linkByte;
      end
   end

   // reset arming and volatile write target
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         resetArmed <= 1'b0;
         volTarget  <= 1'b0;
      end else begin
         if (evValid && linkIdx == 2'h0) resetArmed <= doArm;
         if (doWrenV) volTarget <= 1'b1;
         else if (doWren || doLiveWr || doNvWr) volTarget <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // system side: register contents
   // ------------------------------------------------------------------
   // persistent defaults; latch and busy defaults are constants
   always_ff @(posedge sys_clk) begin
      if (rst) nvBits <= NV_RESET[7:2];                          // [R21]
      else if (doNvWr) nvBits <= wrData[7:2];                    // [R22]
   end

   // live protection bits
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         liveBits <= NV_RESET[7:2];                         // [R24] [R25]
      end else if (doReset) begin
         liveBits <= nvBits;                                // [R24] [R25]
      end else if (doLiveWr) begin
         liveBits <= wrData[7:2];                                // [R9]
      end else if (doNvWr) begin
         liveBits[LOCK_BIT] <= wrData[LOCK_BIT];                 // [R5]
         liveBits[TB_BIT]   <= wrData[TB_BIT];                   // [R8]
      end
   end

   // write-enable latch; register writes leave it alone [R16]
   always_ff @(posedge sys_clk) begin
      if (rst || doReset) begin
         write_enable_latch <= LATCH_DEFAULT;                                  // [R15]
      end else if (doWren || doWrenV) begin
         write_enable_latch <= 1'b1;                                           // [R11]
      end else if (doWrdi || doClsr) begin
         write_enable_latch <= 1'b0;                                     // [R12] [R14]
      end else if (state == ST_ARRAY && opDone &&
                   !programFail && !eraseFail &&
                   !progFail && !eraseFailFlag) begin
         write_enable_latch <= 1'b0;                                           // [R13]
      end
   end

   // failure flags, sampled only while busy; a set beats a clear
   always_ff @(posedge sys_clk) begin
      if (rst || doReset) begin
         progFail      <= 1'b0;
         eraseFailFlag <= 1'b0;
      end else begin
         progFail <= (state == ST_ARRAY && programFail) ||
                     (progFail && !doClsr);                     // [R20]
         eraseFailFlag <= (state == ST_ARRAY && eraseFail) ||
                          (eraseFailFlag && !doClsr);           // [R20]
      end
   end

   // ------------------------------------------------------------------
   // system side: operation state
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || doReset) begin
         state   <= ST_IDLE;
         nvCount <= 7'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (doProg || doErase) state <= ST_ARRAY;
               else if (doNvWr) begin
                  state   <= ST_NVWRITE;
                  nvCount <= NV_WRITE_LOAD;
               end
            end
            ST_ARRAY: begin
               if (opDone) begin
                  if (programFail || eraseFail || progFail ||
                      eraseFailFlag)
                     state <= ST_FAILED;                        // [R20]
                  else
                     state <= ST_IDLE;
               end
            end
            ST_NVWRITE: begin
               if (nvCount == 7'h00) state <= ST_IDLE;
               else nvCount <= nvCount - 7'h01;
            end
            ST_FAILED: begin
               if (doClsr) state <= ST_IDLE;                    // [R20]
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // engine strobes, one cycle each
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         opStart    <= 1'b0;
         opErase    <= 1'b0;
         suspendReq <= 1'b0;
         abortOp    <= 1'b0;
      end else begin
         opStart    <= (doProg || doErase) && !busy;            // [R17]
         opErase    <= doErase && !busy;
         suspendReq <= doSuspend;                               // [R19]
         abortOp    <= doReset && busy;
      end
   end

   // ------------------------------------------------------------------
   // system side: outputs and publication to the link
   // ------------------------------------------------------------------
   logic [7:0] liveNow;
   logic [7:0] nvNow;
   logic [7:0] status2Now;

   assign liveNow    = {liveBits, write_enable_latch, busy};
   assign nvNow      = {nvBits, LATCH_DEFAULT, BUSY_DEFAULT};   // [R22]
   assign status2Now = {1'b0, eraseFailFlag, progFail, 5'h00};

   // register images and protection range controls
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status1Live       <= {NV_RESET[7:2], LATCH_DEFAULT,
                               BUSY_DEFAULT};
         status1Persist    <= {NV_RESET[7:2], LATCH_DEFAULT,
                               BUSY_DEFAULT};
         blockProtect      <= 3'h0;
         protectFromBottom <= 1'b0;
         sectorGranule     <= 1'b0;
      end else begin
         status1Live       <= liveNow;
         status1Persist    <= nvNow;
         blockProtect      <= liveBits[BP_MSB:BP_LSB];          // [R9]
         protectFromBottom <= liveBits[TB_BIT];                 // [R7]
         sectorGranule     <= liveBits[SIZE_BIT];               // [R23]
      end
   end

   // snapshot handshake; a new snapshot waits for the previous ack
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pubReq  <= 1'b0;
         pubData <= 24'h000000;
      end else if (pubReq == ackS2 &&
                   pubData != {status2Now, nvNow, liveNow}) begin
         pubReq  <= ~pubReq;
         pubData <= {status2Now, nvNow, liveNow};
      end
   end

endmodule : flash_status_protect_regs

// File: verification/flash_status_checker.sv
// concurrent checks on the status bank ports
// assumes binding to flash_status_protect_regs, one sys_clk domain
`timescale 1ns/1ps
module flash_status_checker
   import flash_status_pkg::*;
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // engine side
   input wire logic       opStart,
   input wire logic       opErase,
   input wire logic       suspendReq,
   input wire logic       abortOp,
   input wire logic       opDone,
   input wire logic       programFail,
   input wire logic       eraseFail,
   // register images
   input wire logic [7:0] status1Live,
   input wire logic [7:0] status1Persist
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_reset_clear;
      disable iff (1'b0) rst |=> status1Live == 8'h00 && !opStart;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("live bits not cleared by reset");
   property p_persist_low;
      status1Persist[1:0] == 2'b00;
   endproperty
   a_persist_low: assert property (p_persist_low)
      else $error("fixed default bits changed");
   property p_start_wel;
      opStart |-> status1Live[WEL_BIT] && !status1Live[BUSY_BIT];
   endproperty
   a_start_wel: assert property (p_start_wel)
      else $error("operation started without latch or while busy");
   property p_erase_pair;
      opErase |-> opStart;
   endproperty
   a_erase_pair: assert property (p_erase_pair)
      else $error("erase flag without start");
   property p_start_busy;
      opStart |=> !opStart ##[0:2] status1Live[BUSY_BIT];
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("busy not shown after start");
   property p_suspend_busy;
      suspendReq |-> status1Live[BUSY_BIT];
   endproperty
   a_suspend_busy: assert property (p_suspend_busy)
      else $error("suspend passed while idle");
   property p_abort_busy;
      abortOp |-> status1Live[BUSY_BIT];
   endproperty
   a_abort_busy: assert property (p_abort_busy)
      else $error("abort while idle");
   property p_done_clear;
      opDone && !programFail && !eraseFail && status1Live[BUSY_BIT]
         |-> ##[1:3] status1Live[1:0] == 2'b00;
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("latch or busy kept after success");
   property p_fail_hold;
      opDone && (programFail || eraseFail) && status1Live[BUSY_BIT]
         |-> ##2 (status1Live[1:0] == 2'b11) [*4];
   endproperty
   a_fail_hold: assert property (p_fail_hold)
      else $error("busy dropped after failure");
endmodule : flash_status_checker

bind flash_status_protect_regs flash_status_checker u_flash_status_checker (
   .sys_clk(sys_clk), .rst(rst), .opStart(opStart), .opErase(opErase),
   .suspendReq(suspendReq), .abortOp(abortOp), .opDone(opDone),
   .programFail(programFail), .eraseFail(eraseFail),
   .status1Live(status1Live), .status1Persist(status1Persist));

// File: verification/flash_status_protect_regs_tb.sv
// self-checking bench for the status bank, frames sent by host model
// assumes the checker is bound to the design by its own file
`timescale 1ns/1ps
module flash_status_protect_regs_tb;
   import flash_status_pkg::*;
   logic       sys_clk, rst, protectPinN, fourWireMode, fourBitIoMode;
   logic       opDone, programFail, eraseFail, spiClk, spiSelN;
   logic       spiDataIn, spiDataOut, spiOutEnN, opStart, opErase;
   logic       suspendReq, abortOp, protectFromBottom, sectorGranule;
   logic [7:0] status1Live, status1Persist, rx;
   logic [2:0] blockProtect;
   int         errorCnt = 0, nTests = 0, starts = 0, susp = 0, aborts = 0;
   // pin and mode levels, data, expected persist
   logic [2:0] lv [6] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b100, 3'b000};
   logic [7:0] wd [6] = '{8'hA8, 8'hA8, 8'hA4, 8'hA8, 8'h24, 8'h28};
   logic [7:0] ex [6] = '{8'hA4, 8'hA8, 8'hA4, 8'hA8, 8'h24, 8'h28};

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   flash_status_protect_regs u_flash_status_protect_regs (
      .sys_clk(sys_clk), .rst(rst), .spiClk(spiClk), .spiSelN(spiSelN),
      .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
      .spiOutEnN(spiOutEnN), .protectPinN(protectPinN),
      .fourWireMode(fourWireMode), .fourBitIoMode(fourBitIoMode),
      .opStart(opStart), .opErase(opErase), .suspendReq(suspendReq),
      .abortOp(abortOp), .opDone(opDone), .programFail(programFail),
      .eraseFail(eraseFail), .status1Live(status1Live),
      .status1Persist(status1Persist), .blockProtect(blockProtect),
      .protectFromBottom(protectFromBottom),
      .sectorGranule(sectorGranule));
   host_spi_model u_host_spi_model (
      .spiClk(spiClk), .spiSelN(spiSelN), .spiDataIn(spiDataIn),
      .spiDataOut(spiDataOut), .spiOutEnN(spiOutEnN));
   // count engine pulses
   always @(negedge sys_clk) begin
      if (opStart === 1'b1) starts++;
      if (suspendReq === 1'b1) susp++;
      if (abortOp === 1'b1) aborts++;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nTests++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input int nb, input logic [7:0] op,
                      input logic [7:0] d1);
      u_host_spi_model.xfer(nb, {op, d1, 8'h00}, rx);
   endtask : cmd
   // engine completion, pass or fail
   task automatic done(input logic pf);
      @(negedge sys_clk);
      programFail = pf;
      opDone = 1'b1;
      @(negedge sys_clk);
      opDone = 1'b0;
      programFail = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask : done
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : giveVerdict

   // watchdog
   initial begin
      #400000;
      errorCnt++;
      giveVerdict();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      {protectPinN, fourWireMode, fourBitIoMode} = 3'b100;
      {opDone, programFail, eraseFail} = 3'b000;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk(status1Live, 8'h00);
      chk(status1Persist, NV_RESET);
      cmd(1, OP_ENABLE_WRITES, 8'h00);
      chk(status1Live, 8'h02);
      cmd(3, OP_STATUS1_READ, 8'h00);
      chk(rx, 8'h02);
      cmd(1, OP_DISABLE_WRITES, 8'h00);
      chk(status1Live, 8'h00);
      cmd(1, OP_PROGRAM, 8'h00);
      chk(8'(starts), 8'h00);
      cmd(1, OP_ENABLE_WRITES, 8'h00);
      cmd(1, OP_ERASE, 8'h00);
      chk(status1Live, 8'h03);
      cmd(1, OP_DISABLE_WRITES, 8'h00);
      chk(status1Live, 8'h03);
      cmd(1, OP_SUSPEND, 8'h00);
      chk(8'(susp), 8'h01);
      done(1'b0);
      chk(status1Live, 8'h00);
      cmd(1, OP_SUSPEND, 8'h00);
      chk(8'(susp), 8'h01);
      cmd(1, OP_ENABLE_WRITES, 8'h00);
      cmd(2, OP_REG_WRITE, 8'hA7);
      repeat (60) @(negedge sys_clk);
      chk(status1Persist, 8'hA4);
      chk(status1Live, 8'hA2);
      for (int i = 0; i < 6; i++) begin
         @(negedge sys_clk);
         {protectPinN, fourWireMode, fourBitIoMode} = lv[i];
         cmd(2, OP_REG_WRITE, wd[i]);
         repeat (60) @(negedge sys_clk);
         chk(status1Persist, ex[i]);
      end
      chk(status1Live, 8'h22);
      cmd(1, OP_PROGRAM, 8'h00);
      done(1'b1);
      chk(status1Live, 8'h23);
      cmd(1, OP_CLEAR_STATUS, 8'h00);
      chk(status1Live, 8'h20);
      cmd(1, OP_RESET_ARM, 8'h00);
      cmd(1, OP_RESET_GO, 8'h00);
      chk(status1Live, 8'h28);
      chk({5'h00, blockProtect}, 8'h02);
      chk({6'h00, protectFromBottom, sectorGranule}, 8'h02);
      cmd(1, OP_ENABLE_WRITES, 8'h00);
      cmd(1, OP_PROGRAM, 8'h00);
      cmd(1, OP_RESET_ARM, 8'h00);
      cmd(1, OP_RESET_GO, 8'h00);
      chk(8'(aborts), 8'h01);
      chk(status1Live, 8'h28);
      cmd(1, OP_ENABLE_VOLATILE, 8'h00);
      cmd(2, OP_REG_WRITE, 8'h5C);
      chk(status1Live, 8'h5E);
      giveVerdict();
   end
endmodule : flash_status_protect_regs_tb

// File: verification/host_spi_model.sv
// host controller issuing serial register frames, mode 0
// assumes the link clock stands still between frames, 32 ns period
`timescale 1ns/1ps
module host_spi_model (
   // link pins toward the device
   output logic      spiClk,
   output logic      spiSelN,
   output logic      spiDataIn,
   // reply from the device
   input  wire logic spiDataOut,
   input  wire logic spiOutEnN
);
   initial begin
      spiClk = 1'b0;
      spiSelN = 1'b1;
      spiDataIn = 1'b0;
   end
   // frame of nb bytes, tx left aligned, rx keeps last byte
   task automatic xfer(input int nb, input logic [23:0] tx,
                       output logic [7:0] rx);
      rx = 8'h00;
      #7 spiSelN = 1'b0;
      for (int i = 0; i < nb * 8; i++) begin
         spiDataIn = tx[23 - i];
         #16 spiClk = 1'b1;
         rx = {rx[6:0], spiOutEnN ? 1'bx : spiDataOut};
         #16 spiClk = 1'b0;
      end
      #16 spiSelN = 1'b1;
      spiDataIn = ~spiDataIn; // no stale level
      #400;
   endtask : xfer
endmodule : host_spi_model
